/* rtl/debug_ctrl_pkg.sv */
// constants and types shared by the debug breakpoint control block
package debug_ctrl_pkg;

    // ************************************************************
    // register geometry
    // ************************************************************
    localparam int          SCAN_W          = 32;
    localparam int          CTRL_W          = 18;
    localparam logic [17:0] CTRL_RESET      = 18'h0_0000;
    localparam logic [4:0]  PICK_CONTROL    = 5'h0d;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int          SEQ_LSB         = 16;
    localparam int          FORCE_BIT       = 15;
    localparam int          IDR_EN_BIT      = 14;
    localparam int          TRACE_EN_BIT    = 13;
    localparam int          FREEZE_SEL_BIT  = 12;
    localparam int          RANGE_B_BIT     = 11;
    localparam int          QUAL_B_LSB      = 6;
    localparam int          RANGE_A_BIT     = 5;
    localparam int          QUAL_A_LSB      = 0;
    localparam int          QUAL_W          = 5;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        SEQ_OFF           = 2'b00,
        SEQ_TRACE_AFTER_B = 2'b01,
        SEQ_B_AFTER_A     = 2'b10,
        SEQ_CHAIN         = 2'b11
    } seq_mode_t;

    localparam logic [1:0]  PRIV_ANY        = 2'h0;
    localparam logic [1:0]  PRIV_USER       = 2'h2;
    localparam logic [1:0]  PRIV_SUPER      = 2'h3;
    localparam logic [2:0]  ACC_ANY         = 3'h1;
    localparam logic [2:0]  ACC_FETCH       = 3'h2;
    localparam logic [2:0]  ACC_DATA        = 3'h3;
    localparam logic [2:0]  ACC_FLOW        = 3'h4;
    localparam logic [2:0]  ACC_WRITE       = 3'h5;
    localparam logic [2:0]  ACC_READ        = 3'h6;

    localparam logic [1:0]  MODE_NORMAL     = 2'h0;
    localparam logic [1:0]  MODE_LOW_POWER  = 2'h1;
    localparam logic [1:0]  MODE_DEBUG      = 2'h2;

endpackage

/* rtl/access_attr_if.sv */
// attributes of the current processor bus access, shared by both channels
`timescale 1ns/10ps
interface access_attr_if;
    logic valid;
    logic fetch;
    logic change_of_flow;
    logic write;
    logic user;

    modport source (output valid, output fetch, output change_of_flow, output write,
                    output user);
    modport sink   (input valid, input fetch, input change_of_flow, input write,
                    input user);
endinterface

/* rtl/breakpoint_qualifier.sv */
// access type and privilege qualification for one memory breakpoint channel
`timescale 1ns/10ps
module breakpoint_qualifier (
    // access attributes
    access_attr_if.sink       acc,
    // channel setup and address compare
    input  wire logic [4:0]   qualifier_i,
    input  wire logic         range_polarity_i,
    input  wire logic         addr_in_range_i,
    input  wire logic         suspend_i,
    // qualified match towards the counter
    output logic              qualified_o
);

    function automatic logic type_ok(input logic [2:0] t, input logic f,
                                     input logic c, input logic w);
        unique case (t)
            debug_ctrl_pkg::ACC_ANY:   type_ok = 1'b1;
            debug_ctrl_pkg::ACC_FETCH: type_ok = f;
            debug_ctrl_pkg::ACC_DATA:  type_ok = !f;
            debug_ctrl_pkg::ACC_FLOW:  type_ok = f && c;
            debug_ctrl_pkg::ACC_WRITE: type_ok = !f && w;
            debug_ctrl_pkg::ACC_READ:  type_ok = !f && !w;
            default:                   type_ok = 1'b0;
        endcase
    endfunction

    logic priv_ok;
    logic hit;

    always_comb begin
        unique case (qualifier_i[4:3])
            debug_ctrl_pkg::PRIV_ANY:   priv_ok = 1'b1;
            debug_ctrl_pkg::PRIV_USER:  priv_ok = acc.user;
            debug_ctrl_pkg::PRIV_SUPER: priv_ok = !acc.user;
            default:                    priv_ok = 1'b0;
        endcase
        hit = addr_in_range_i ^ range_polarity_i;
        qualified_o = acc.valid && hit && priv_ok && !suspend_i &&
                      type_ok(qualifier_i[2:0], acc.fetch, acc.change_of_flow, acc.write);
    end

endmodule // breakpoint_qualifier

/* rtl/control_scan_link.sv */
// serial access to the control register on the test clock
`timescale 1ns/10ps
module control_scan_link (
    // test clock and reset
    input  wire logic                 tck_i,
    input  wire logic                 test_logic_reset_i,
    // scan controls from the tap
    input  wire logic [4:0]           register_pick_i,
    input  wire logic                 read_not_write_i,
    input  wire logic                 capture_dr_i,
    input  wire logic                 shift_dr_i,
    input  wire logic                 update_dr_i,
    input  wire logic                 tdi_i,
    output logic                      tdo_o,
    // control word towards the core
    output logic [17:0]               control_o,
    output logic                      change_toggle_o
);

    typedef struct packed {
        logic [31:0] shift;
        logic [17:0] ctrl;
        logic        toggle;
    } link_state_t;

    link_state_t link_reg;
    link_state_t link_next;
    logic        picked;

    always_comb begin
        link_next = link_reg;
        picked = register_pick_i == debug_ctrl_pkg::PICK_CONTROL;
        if (test_logic_reset_i) begin
            link_next.ctrl   = debug_ctrl_pkg::CTRL_RESET;
            // an unknown toggle before the first reset still lands on a known level
            if (link_reg.toggle) link_next.toggle = 1'b0; else link_next.toggle = 1'b1;
        end else if (picked && capture_dr_i) begin
            link_next.shift = {14'h0000, link_reg.ctrl};
        end else if (picked && shift_dr_i) begin
            link_next.shift = {tdi_i, link_reg.shift[31:1]};
        end else if (picked && update_dr_i && !read_not_write_i) begin
            link_next.ctrl   = link_reg.shift[17:0];
            link_next.toggle = !link_reg.toggle;
        end
    end

    always_ff @(posedge tck_i) begin
        link_reg <= link_next;
    end

    assign tdo_o           = link_reg.shift[0];
    assign control_o       = link_reg.ctrl;
    assign change_toggle_o = link_reg.toggle;

endmodule // control_scan_link

/* rtl/debug_breakpoint_control.sv */
// debug event control register and the breakpoint qualification it drives
//
// How it works
// - 32-bit control register; bits 31..18 read zero; all bits reset zero
// - two-bit sequence field in bits 17..16 defers later events; reset clears
// - sequence 00: channels and trace behave without sequencing
// - sequence 01: channel B raises nothing, arms trace counting
// - sequence 10: channel A raises nothing, arms channel B
// - sequence 11: no breakpoints; A then B arms trace counting
// - bit 15 forces a debug request; reset clears it
// - forced request persists after leaving debug until bit cleared
// - bit 14 gates the internal halt input as a request source
// - bit 13 enables trace, further shaped by the sequence field
// - bit 12 makes channel B freeze history instead of breaking
// - frozen history takes no updates until its flag clears
// - range polarity bits select inside or outside the address range
// - five-bit qualifier per channel; zero disables; reset clears
// - codes 1..6: any, fetch, data, flow change, write, read
// - codes 17..22: same six, user level only
// - codes 25..30: same six, supervisor level only
// - host reaches the register with pick code 01101 and a data scan
// - processor mode reads 10 while in debug mode
// - forced halt flag sets on debug entry while bit 15 set
`timescale 1ns/10ps
module debug_breakpoint_control (
    // core clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // test access port, on the test clock
    input  wire logic         tck_i,
    input  wire logic         test_logic_reset_i,
    input  wire logic [4:0]   register_pick_field_i,
    input  wire logic         read_not_write_i,
    input  wire logic         capture_dr_i,
    input  wire logic         shift_dr_i,
    input  wire logic         update_dr_i,
    input  wire logic         tdi_i,
    output logic              tdo_o,
    // processor bus access
    input  wire logic         access_valid_i,
    input  wire logic         access_fetch_i,
    input  wire logic         access_change_of_flow_i,
    input  wire logic         access_write_i,
    input  wire logic         access_user_i,
    // address compare and counter results
    input  wire logic         chan_a_in_range_i,
    input  wire logic         chan_b_in_range_i,
    input  wire logic         chan_a_occurrence_i,
    input  wire logic         chan_b_occurrence_i,
    input  wire logic         trace_zero_i,
    // processor status
    input  wire logic         debug_ack_i,
    input  wire logic         low_power_i,
    input  wire logic         leave_debug_i,
    input  wire logic         internal_halt_input_n_i,
    input  wire logic         history_write_i,
    // qualified matches towards the counters
    output logic              chan_a_qualified_o,
    output logic              chan_b_qualified_o,
    output logic              trace_count_enable_o,
    // requests to the processor
    output logic              debug_request_o,
    output logic              breakpoint_request_o,
    output logic              history_write_o,
    // status towards the status register
    output logic [1:0]        processor_mode_field_o,
    output logic              forced_halt_flag_o,
    output logic              hardware_halt_flag_o,
    output logic              breakpoint_flag_o,
    output logic              trace_flag_o,
    output logic              history_frozen_flag_o,
    output logic              seq_a_armed_o,
    output logic              seq_b_armed_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_s3;
        logic [17:0] ctrl;
        logic        a_armed;
        logic        b_armed;
        logic        frozen;
        logic        forced_flag;
        logic        hw_flag;
        logic        brk_flag;
        logic        trace_flag;
        logic        ack_d;
        logic        brk_pending;
        logic        dbg_req;
        logic        brk_req;
        logic        trace_en;
        logic        hist_wr;
        logic [1:0]  mode;
    } core_state_t;

    core_state_t             core_reg;
    core_state_t             core_next;

    logic [17:0]             link_ctrl;
    logic                    link_toggle;
    logic                    qual_a;
    logic                    qual_b;
    logic                    suspend_b;
    debug_ctrl_pkg::seq_mode_t seq_mode;
    logic                    force_bit;
    logic                    idr_en;
    logic                    trace_bit;
    logic                    freeze_sel;
    logic                    occ_a;
    logic                    occ_b;
    logic                    b_live;
    logic                    brk_evt;
    logic                    freeze_evt;
    logic                    trace_evt;
    logic                    entry;

    access_attr_if           attr ();

    assign attr.valid          = access_valid_i;
    assign attr.fetch          = access_fetch_i;
    assign attr.change_of_flow = access_change_of_flow_i;
    assign attr.write          = access_write_i;
    assign attr.user           = access_user_i;

    // ************************************************************
    // serial register on the test clock
    // ************************************************************
    control_scan_link u_link (
        .tck_i              (tck_i),
        .test_logic_reset_i (test_logic_reset_i),
        .register_pick_i    (register_pick_field_i),
        .read_not_write_i   (read_not_write_i),
        .capture_dr_i       (capture_dr_i),
        .shift_dr_i         (shift_dr_i),
        .update_dr_i        (update_dr_i),
        .tdi_i              (tdi_i),
        .tdo_o              (tdo_o),
        .control_o          (link_ctrl),
        .change_toggle_o    (link_toggle)
    );

    // ************************************************************
    // channel qualification
    // ************************************************************
    breakpoint_qualifier u_chan_a (
        .acc              (attr.sink),
        .qualifier_i      (core_reg.ctrl[debug_ctrl_pkg::QUAL_A_LSB +: debug_ctrl_pkg::QUAL_W]),
        .range_polarity_i (core_reg.ctrl[debug_ctrl_pkg::RANGE_A_BIT]),
        .addr_in_range_i  (chan_a_in_range_i),
        .suspend_i        (1'b0),
        .qualified_o      (qual_a)
    );

    breakpoint_qualifier u_chan_b (
        .acc              (attr.sink),
        .qualifier_i      (core_reg.ctrl[debug_ctrl_pkg::QUAL_B_LSB +: debug_ctrl_pkg::QUAL_W]),
        .range_polarity_i (core_reg.ctrl[debug_ctrl_pkg::RANGE_B_BIT]),
        .addr_in_range_i  (chan_b_in_range_i),
        .suspend_i        (suspend_b),
        .qualified_o      (qual_b)
    );

    assign chan_a_qualified_o = qual_a;
    assign chan_b_qualified_o = qual_b;

    // ************************************************************
    // field decode
    // ************************************************************
    always_comb begin
        seq_mode   = debug_ctrl_pkg::seq_mode_t'(core_reg.ctrl[debug_ctrl_pkg::SEQ_LSB +: 2]);
        force_bit  = core_reg.ctrl[debug_ctrl_pkg::FORCE_BIT];
        idr_en     = core_reg.ctrl[debug_ctrl_pkg::IDR_EN_BIT];
        trace_bit  = core_reg.ctrl[debug_ctrl_pkg::TRACE_EN_BIT];
        freeze_sel = core_reg.ctrl[debug_ctrl_pkg::FREEZE_SEL_BIT];
        suspend_b  = seq_mode[1] && !core_reg.a_armed;
        occ_a      = chan_a_occurrence_i;
        occ_b      = chan_b_occurrence_i && !suspend_b;
    end

    // ************************************************************
    // sequencing and requests
    // ************************************************************
    always_comb begin
        core_next = core_reg;
        // two-flop crossing of the update toggle, third flop for the edge
        core_next.tog_s1 = link_toggle;
        core_next.tog_s2 = core_reg.tog_s1;
        core_next.tog_s3 = core_reg.tog_s2;
        // word is stable long before the toggle edge is seen here
        if (core_reg.tog_s2 != core_reg.tog_s3) begin
            core_next.ctrl = link_ctrl;
        end

        b_live     = 1'b0;
        brk_evt    = 1'b0;
        freeze_evt = 1'b0;
        unique case (seq_mode)
            debug_ctrl_pkg::SEQ_OFF: begin
                b_live  = occ_b;
                brk_evt = occ_a;
                core_next.trace_en = trace_bit;
            end
            debug_ctrl_pkg::SEQ_TRACE_AFTER_B: begin
                brk_evt = occ_a;
                if (occ_b) begin
                    core_next.b_armed = 1'b1;
                end
                core_next.trace_en = trace_bit && core_reg.b_armed;
            end
            debug_ctrl_pkg::SEQ_B_AFTER_A: begin
                b_live = occ_b;
                if (occ_a) begin
                    core_next.a_armed = 1'b1;
                end
                core_next.trace_en = trace_bit;
            end
            debug_ctrl_pkg::SEQ_CHAIN: begin
                if (occ_a) begin
                    core_next.a_armed = 1'b1;
                end
                if (occ_b) begin
                    core_next.b_armed = 1'b1;
                end
                core_next.trace_en = trace_bit && core_reg.b_armed;
            end
        endcase

        if (b_live) begin
            freeze_evt = freeze_sel;
            brk_evt    = brk_evt || !freeze_sel;
        end
        trace_evt = trace_zero_i && core_reg.trace_en;

        entry = debug_ack_i && !core_reg.ack_d;
        core_next.ack_d = debug_ack_i;

        // exit clears the occurrence flags; a same-cycle set still wins
        if (leave_debug_i) begin
            core_next.a_armed     = 1'b0;
            core_next.b_armed     = 1'b0;
            core_next.frozen      = 1'b0;
            core_next.forced_flag = 1'b0;
            core_next.hw_flag     = 1'b0;
            core_next.brk_flag    = 1'b0;
            core_next.trace_flag  = 1'b0;
            core_next.brk_pending = 1'b0;
            core_next.a_armed = occ_a && seq_mode[1];
            core_next.b_armed = occ_b && seq_mode[0];
        end
        if (seq_mode == debug_ctrl_pkg::SEQ_OFF) begin
            core_next.a_armed = 1'b0;
            core_next.b_armed = 1'b0;
        end
        if (seq_mode == debug_ctrl_pkg::SEQ_CHAIN && !core_reg.a_armed) begin
            core_next.b_armed = 1'b0;
        end

        if (freeze_evt) begin
            core_next.frozen = 1'b1;
        end
        core_next.hist_wr = history_write_i && !core_next.frozen;

        if (brk_evt) begin
            core_next.brk_pending = 1'b1;
        end
        if (entry) begin
            if (force_bit) begin
                core_next.forced_flag = 1'b1;
            end
            if (idr_en && !internal_halt_input_n_i) begin
                core_next.hw_flag = 1'b1;
            end
            if (core_reg.brk_pending) begin
                core_next.brk_flag = 1'b1;
            end
            if (core_reg.dbg_req && trace_zero_i && core_reg.trace_en) begin
                core_next.trace_flag = 1'b1;
            end
        end

        core_next.dbg_req = force_bit || (idr_en && !internal_halt_input_n_i) || trace_evt;
        core_next.brk_req = brk_evt;

        if (debug_ack_i) begin
            core_next.mode = debug_ctrl_pkg::MODE_DEBUG;
        end else if (low_power_i) begin
            core_next.mode = debug_ctrl_pkg::MODE_LOW_POWER;
        end else begin
            core_next.mode = debug_ctrl_pkg::MODE_NORMAL;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            core_reg      <= '0;
            core_reg.ctrl <= debug_ctrl_pkg::CTRL_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign trace_count_enable_o   = core_reg.trace_en;
    assign debug_request_o        = core_reg.dbg_req;
    assign breakpoint_request_o   = core_reg.brk_req;
    assign history_write_o        = core_reg.hist_wr;
    assign processor_mode_field_o = core_reg.mode;
    assign forced_halt_flag_o     = core_reg.forced_flag;
    assign hardware_halt_flag_o   = core_reg.hw_flag;
    assign breakpoint_flag_o      = core_reg.brk_flag;
    assign trace_flag_o           = core_reg.trace_flag;
    assign history_frozen_flag_o  = core_reg.frozen;
    assign seq_a_armed_o          = core_reg.a_armed;
    assign seq_b_armed_o          = core_reg.b_armed;

endmodule // debug_breakpoint_control

/* bench/debug_breakpoint_control_sva.sv */
// port assertions for the debug breakpoint control block
`timescale 1ns/10ps
module debug_breakpoint_control_sva (
    // clock, reset and causes
    input wire logic       mclk_i, rst_n_i, access_valid_i, debug_ack_i,
    input wire logic       chan_a_occurrence_i, chan_b_occurrence_i,
    // watched outputs
    input wire logic       chan_a_qualified_o, chan_b_qualified_o, breakpoint_request_o,
    input wire logic       history_write_o, forced_halt_flag_o, history_frozen_flag_o,
    input wire logic       seq_a_armed_o, seq_b_armed_o,
    input wire logic [1:0] processor_mode_field_o
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    qual_a_access_a: assert property (chan_a_qualified_o |-> access_valid_i)
        else $error("channel a qualified with no access");
    qual_b_access_a: assert property (chan_b_qualified_o |-> access_valid_i)
        else $error("channel b qualified with no access");
    debug_mode_a: assert property (debug_ack_i |=> processor_mode_field_o == 2'h2)
        else $error("mode field not debug");
    brk_cause_a: assert property (breakpoint_request_o
        |-> $past(chan_a_occurrence_i || chan_b_occurrence_i)) else $error("breakpoint no cause");
    freeze_nobrk_a: assert property ($rose(history_frozen_flag_o)
        |-> $past(chan_b_occurrence_i) && !breakpoint_request_o) else $error("bad freeze");
    frozen_hold_a: assert property (history_frozen_flag_o && $past(history_frozen_flag_o)
        |-> !history_write_o) else $error("history written while frozen");
    arm_a_cause_a: assert property ($rose(seq_a_armed_o) |-> $past(chan_a_occurrence_i))
        else $error("a armed without event");
    arm_b_cause_a: assert property ($rose(seq_b_armed_o) |-> $past(chan_b_occurrence_i))
        else $error("b armed without event");
    forced_flag_a: assert property ($rose(forced_halt_flag_o) |-> debug_ack_i)
        else $error("forced flag outside debug entry");
endmodule // debug_breakpoint_control_sva

bind debug_breakpoint_control debug_breakpoint_control_sva chk (.*);

/* bench/jtag_host_model.sv */
// serial debug host that scans the control register
`timescale 1ns/10ps
module jtag_host_model (
    // scan pins towards the block
    output logic       tck_o, tlr_o, rnw_o, capture_o, shift_o, update_o, tdi_o,
    output logic [4:0] pick_o,
    // serial data back
    input  wire logic  tdo_i
);
    initial begin
        {tck_o, tlr_o, rnw_o, capture_o, shift_o, update_o, tdi_o} = 7'h00;
        pick_o = 5'h0c;
    end
    // test clock runs only inside frames
    task automatic tick();
        #3 tck_o = 1'b1;
        #3 tck_o = 1'b0;
    endtask
    task automatic reset_link();
        tlr_o = 1'b1;
        tick();
        tlr_o = 1'b0;
    endtask
    // pick code, capture, 32 shifts, update
    task automatic scan(input logic [31:0] wdat, input logic rnw, output logic [31:0] rdat);
        pick_o = debug_ctrl_pkg::PICK_CONTROL;
        rnw_o = rnw;
        capture_o = 1'b1;
        tick();
        capture_o = 1'b0;
        shift_o = 1'b1;
        for (int k = 0; k < 32; k++) begin
            tdi_o = wdat[k];
            rdat[k] = tdo_i;
            tick();
        end
        shift_o = 1'b0;
        tdi_o = ~tdi_o;
        update_o = 1'b1;
        tick();
        update_o = 1'b0;
        pick_o = 5'h0c;
        // spacing for the crossing
        #72;
    endtask
endmodule // jtag_host_model

/* bench/debug_breakpoint_control_tb.sv */
// self-checking bench for the debug breakpoint control block
`timescale 1ns/10ps
module debug_breakpoint_control_tb;
    logic mclk_i, rst_n_i, tck_i, test_logic_reset_i, read_not_write_i, capture_dr_i;
    logic shift_dr_i, update_dr_i, tdi_i, tdo_o, access_valid_i, access_fetch_i;
    logic access_change_of_flow_i, access_write_i, access_user_i, chan_a_in_range_i;
    logic chan_b_in_range_i, chan_a_occurrence_i, chan_b_occurrence_i, trace_zero_i;
    logic debug_ack_i, low_power_i, leave_debug_i, internal_halt_input_n_i, history_write_i;
    logic chan_a_qualified_o, chan_b_qualified_o, trace_count_enable_o, debug_request_o;
    logic breakpoint_request_o, history_write_o, forced_halt_flag_o, hardware_halt_flag_o;
    logic breakpoint_flag_o, trace_flag_o, history_frozen_flag_o, seq_a_armed_o, seq_b_armed_o;
    logic [4:0]  register_pick_field_i;
    logic [1:0]  processor_mode_field_o;
    logic [31:0] rdat;
    int          num_errors = 0;
    int          compares = 0;
    debug_breakpoint_control uut (.*);
    jtag_host_model host (.tck_o(tck_i), .tlr_o(test_logic_reset_i), .rnw_o(read_not_write_i),
        .capture_o(capture_dr_i), .shift_o(shift_dr_i), .update_o(update_dr_i),
        .tdi_o(tdi_i), .pick_o(register_pick_field_i), .tdo_i(tdo_o));
    always #2 mclk_i = ~mclk_i;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] d);
        host.scan(d, 1'b0, rdat);
        repeat (4) @(negedge mclk_i);
    endtask
    // one cycle of events {a, b, trace, history, leave}, then compare status
    task automatic ev(input logic [4:0] e, input logic [5:0] exp);
        @(negedge mclk_i);
        {chan_a_occurrence_i, chan_b_occurrence_i, trace_zero_i, history_write_i} = e[4:1];
        leave_debug_i = e[0];
        @(negedge mclk_i);
        {chan_a_occurrence_i, chan_b_occurrence_i, trace_zero_i, history_write_i} = 4'h0;
        leave_debug_i = 1'b0;
        chk("status", 32'({breakpoint_request_o, debug_request_o, seq_a_armed_o,
            seq_b_armed_o, history_frozen_flag_o, history_write_o}), 32'(exp));
    endtask
    // attributes a = {in_range, user, write, flow, fetch, valid}
    function automatic logic exp_q(input logic [4:0] c, input logic [5:0] a);
        logic ok;
        case (c[2:0])
            3'h1: ok = 1'b1;
            3'h2: ok = a[1];
            3'h3: ok = !a[1];
            3'h4: ok = a[1] & a[2];
            3'h5: ok = !a[1] & a[3];
            3'h6: ok = !a[1] & !a[3];
            default: ok = 1'b0;
        endcase
        return a[0] & a[5] & ok & ((c[4:3] == 2'h0) | (c[4:3] == 2'h2 & a[4])
            | (c[4:3] == 2'h3 & !a[4]));
    endfunction
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        {mclk_i, rst_n_i, access_valid_i, access_fetch_i, access_change_of_flow_i} = 5'h00;
        {access_write_i, access_user_i, chan_a_in_range_i, chan_b_in_range_i} = 4'h0;
        {chan_a_occurrence_i, chan_b_occurrence_i, trace_zero_i, history_write_i} = 4'h0;
        {debug_ack_i, low_power_i, leave_debug_i} = 3'h0;
        internal_halt_input_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rst_n_i = 1'b1;
        host.reset_link();
        host.scan(32'hffff_ffff, 1'b1, rdat);
        chk("reset value", rdat, 32'h0000_0000);
        @(negedge mclk_i) internal_halt_input_n_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        chk("halt masked", 32'(debug_request_o), 32'h0000_0000);
        wr(32'h0000_4000);
        chk("halt enabled", 32'(debug_request_o), 32'h0000_0001);
        internal_halt_input_n_i = 1'b1;
        wr(32'hffff_8000);
        host.scan(32'h0000_0000, 1'b1, rdat);
        chk("readback", rdat, 32'h0003_8000);
        chk("forced request", 32'(debug_request_o), 32'h0000_0001);
        @(negedge mclk_i) debug_ack_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        chk("mode", 32'(processor_mode_field_o), 32'h0000_0002);
        chk("forced flag", 32'(forced_halt_flag_o), 32'h0000_0001);
        debug_ack_i = 1'b0;
        ev(5'h01, 6'h10);
        wr(32'h0000_0000);
        chk("force cleared", 32'(debug_request_o), 32'h0000_0000);
        // every code, reserved ones never qualify
        for (int c = 0; c < 32; c++) begin
            wr({20'h0_0000, 1'b1, c[4:0], 1'b0, c[4:0]});
            for (int a = 0; a < 64; a++) begin
                @(negedge mclk_i);
                {chan_a_in_range_i, access_user_i, access_write_i} = a[5:3];
                {access_change_of_flow_i, access_fetch_i, access_valid_i} = a[2:0];
                chan_b_in_range_i = !a[5];
                #1;
                chk("chan a", 32'(chan_a_qualified_o), 32'(exp_q(c[4:0], a[5:0])));
                chk("chan b", 32'(chan_b_qualified_o), 32'(exp_q(c[4:0], a[5:0])));
            end
        end
        wr(32'h0002_0041);
        ev(5'h01, 6'h00);
        ev(5'h08, 6'h00);
        ev(5'h10, 6'h08);
        ev(5'h08, 6'h28);
        wr(32'h0001_2041);
        ev(5'h01, 6'h00);
        ev(5'h04, 6'h00);
        ev(5'h08, 6'h04);
        ev(5'h04, 6'h14);
        chk("trace count", 32'(trace_count_enable_o), 32'h0000_0001);
        wr(32'h0003_2041);
        ev(5'h01, 6'h00);
        ev(5'h08, 6'h00);
        ev(5'h10, 6'h08);
        ev(5'h08, 6'h0c);
        wr(32'h0000_1041);
        ev(5'h01, 6'h00);
        ev(5'h02, 6'h01);
        ev(5'h08, 6'h02);
        ev(5'h02, 6'h02);
        ev(5'h01, 6'h00);
        ev(5'h02, 6'h01);
        wr(32'h0000_0041);
        ev(5'h08, 6'h20);
        ev(5'h10, 6'h20);
        stop_test();
    end
endmodule // debug_breakpoint_control_tb
